// File: logic/sdlc_regs.svh
// constants for the serial converter load control block
`ifndef SDLC_REGS_SVH
`define SDLC_REGS_SVH
`define SDLC_WORD_BITS 16
`define SDLC_CODE_BITS 13
`define SDLC_CMD_MSB 15
`define SDLC_CMD_LSB 13
`define SDLC_CODE_MSB 12
`define SDLC_BIT_CNT_W 5
`define SDLC_CODE_RESET 13'h0000
`define SDLC_SETTLE_NS 20000
`define SDLC_CLK_NS 40
`define SDLC_SETTLE_CYCLES ((`SDLC_SETTLE_NS + `SDLC_CLK_NS - 1) / `SDLC_CLK_NS)
`define SDLC_SETTLE_CNT_W 10
// wishbone register offsets (byte addresses)
`define SDLC_ADDR_INPUT 8'h00
`define SDLC_ADDR_CONV 8'h04
`define SDLC_ADDR_STATUS 8'h08
`define SDLC_ADDR_CTRL 8'h0C
`define SDLC_ADDR_COUNT 8'h10
// status bit positions
`define SDLC_ST_SHDN 0
`define SDLC_ST_SETTLED 1
`define SDLC_ST_ACTIVE 2
`endif

// File: logic/sdlc_pkg.sv
// types for the serial converter load control block
package sdlc_pkg;
    typedef enum logic [2:0] {
        SDLC_OP_LOAD_BOTH = 3'h0,
        SDLC_OP_LOAD_INPUT = 3'h1,
        SDLC_OP_RECALL = 3'h2,
        SDLC_OP_IDLE = 3'h3
    } sdlc_op_t;
    typedef struct packed {
        logic select_n;
        logic sclk;
        logic sdata;
    } sdlc_link_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sdlc_wb_req_t;
    typedef enum logic [1:0] {
        SDLC_ST_IDLE = 2'b01,
        SDLC_ST_SHIFT = 2'b10
    } sdlc_state_t;
endpackage

// File: logic/sdlc_top.sv
// serial converter load control: 3-wire link front end with wishbone status
//
// Contract
// - three command bits then 13 code bits, msb first
// - bits gather in a 16-bit shift register
// - select high ignores clock and data
// - data sampled on each rising serial clock
// - word acts on rising edge of select
// - load input, load converter, or copy input
// - command bits all ones enter shutdown
// - shutdown floats amplifier and reference, link active
// - input register kept through shutdown
// - recall or converter update leaves shutdown
// - code is unsigned binary 0 to 8191
// - command x00 loads both, leaves shutdown
// - command x01 loads input register only
// - x10 copies input to converter; 011 idles
// - reset clears input and converter registers
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`include "sdlc_regs.svh"
module sdlc_top #(
    parameter int SETTLE_CYCLES = `SDLC_SETTLE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // 3-wire link pins
    input wire sdlc_pkg::sdlc_link_t link_in,
    // wishbone slave
    input wire sdlc_pkg::sdlc_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // converter side
    output logic [`SDLC_CODE_BITS-1:0] code_value,
    output logic analog_enable,
    output logic settled
);
    import sdlc_pkg::*;

    // pin positions inside the synchronised link vector
    localparam int PIN_SEL = 2;
    localparam int PIN_SCLK = 1;
    localparam int PIN_DATA = 0;

    // word geometry, kept next to the decode that relies on it
    localparam int WORD_BITS = `SDLC_WORD_BITS;
    localparam int CODE_BITS = `SDLC_CODE_BITS;
    localparam int CNT_W = `SDLC_BIT_CNT_W;

    // command decode: middle and low command bits pick the action, except shutdown, which needs all three bits set
    function automatic logic cmd_loads_both(input logic [2:0] c);
        return !c[1] && !c[0];
    endfunction

    function automatic logic cmd_loads_input(input logic [2:0] c);
        return !c[1] && c[0];
    endfunction

    function automatic logic cmd_recalls(input logic [2:0] c);
        return c[1] && !c[0];
    endfunction

    function automatic logic cmd_sleeps(input logic [2:0] c);
        return c == 3'h7;
    endfunction

    // only commands that touch the converter register end shutdown
    function automatic logic cmd_wakes(input logic [2:0] c);
        return cmd_loads_both(c) || cmd_recalls(c);
    endfunction

    // two-stage synchronisers for the pins; first stage feeds only the second
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;

    // pins belong to another domain; reset parks them at the idle-high level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end else begin
            pin_meta <= link_in;
            pin_sync <= pin_meta;
        end
    end

    // previous synchronised levels for edge detection
    logic sclk_prev;
    logic sel_prev;

    // reset value matches the synchroniser reset so no false edge follows reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_prev <= 1'b1;
            sel_prev <= 1'b1;
        end else begin
            sclk_prev <= pin_sync[PIN_SCLK];
            sel_prev <= pin_sync[PIN_SEL];
        end
    end

    // synchronised pin levels
    wire select_n_s = pin_sync[PIN_SEL];
    wire sclk_s = pin_sync[PIN_SCLK];
    wire sdata_s = pin_sync[PIN_DATA];

    // edges; a clock edge counts only while select is low
    wire sclk_rise = sclk_s && !sclk_prev && !select_n_s;
    wire sel_rise = select_n_s && !sel_prev;

    // shift state
    sdlc_state_t state;
    logic [WORD_BITS-1:0] shift_word;
    logic [CNT_W-1:0] bit_cnt;

    // double-buffered registers and power state
    logic [CODE_BITS-1:0] input_reg;
    logic shutdown;
    logic ctrl_hold;

    // settle timer and statistics
    logic [`SDLC_SETTLE_CNT_W-1:0] settle_cnt;
    logic [15:0] word_count;
    logic [15:0] drop_count;

    // shift enable; count saturates at 17 so an overrun stays rejected
    wire frame_open = (state == SDLC_ST_SHIFT);
    wire shift_en = frame_open && sclk_rise;
    wire bit_room = !bit_cnt[4] || (bit_cnt[3:0] == 4'h0);

    // word decode at the select edge
    wire [2:0] cmd = shift_word[`SDLC_CMD_MSB:`SDLC_CMD_LSB];
    wire [CODE_BITS-1:0] code_bits = shift_word[`SDLC_CODE_MSB:0];
    wire word_full = (bit_cnt == 5'(`SDLC_WORD_BITS));
    wire frame_end = sel_rise && frame_open;
    wire word_go = frame_end && word_full && !ctrl_hold;
    wire word_drop = frame_end && (!word_full || ctrl_hold);

    // action strobes, one per command class
    wire do_load_both = word_go && cmd_loads_both(cmd);
    wire do_load_in = word_go && cmd_loads_input(cmd);
    wire do_recall = word_go && cmd_recalls(cmd);
    wire do_shdn = word_go && cmd_sleeps(cmd);
    wire wake = word_go && cmd_wakes(cmd);

    // next values; wake and shutdown never come from the same word
    wire next_enable = !(do_shdn || (shutdown && !wake));
    wire settle_last = (settle_cnt == 10'(SETTLE_CYCLES - 1));

    // link state machine: idle while select high, shifting while low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SDLC_ST_IDLE;
        end else begin
            unique case (state)
                SDLC_ST_IDLE: state <= select_n_s ? SDLC_ST_IDLE : SDLC_ST_SHIFT;
                SDLC_ST_SHIFT: state <= select_n_s ? SDLC_ST_IDLE : SDLC_ST_SHIFT;
                default: state <= SDLC_ST_IDLE;
            endcase
        end
    end

    // shift register, msb arrives first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_word <= 16'h0000;
        end else if (shift_en) begin
            shift_word <= {shift_word[14:0], sdata_s};
        end
    end

    // bit counter, cleared between frames
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
        end else if (!frame_open) begin
            bit_cnt <= 5'h00;
        end else if (shift_en && bit_room) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // input register: survives shutdown untouched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_reg <= `SDLC_CODE_RESET;
        end else if (do_load_both || do_load_in) begin
            input_reg <= code_bits;
        end
    end

    // converter register: direct load or copy from the input register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            code_value <= `SDLC_CODE_RESET;
        end else if (do_load_both || do_recall) begin
            code_value <= do_load_both ? code_bits : input_reg;
        end
    end

    // shutdown flag; a waking word wins over anything else
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutdown <= 1'b0;
        end else if (wake || do_shdn) begin
            shutdown <= !wake;
        end
    end

    // analog enable low floats amplifier and reference
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analog_enable <= 1'b1;
        end else begin
            analog_enable <= next_enable;
        end
    end

    // settle timer after reset or wake; helps the host honour the wait
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settle_cnt <= 10'h000;
            settled <= 1'b0;
        end else if (wake) begin
            settle_cnt <= 10'h000;
            settled <= 1'b0;
        end else if (!settled) begin
            settle_cnt <= settle_cnt + 10'h001;
            settled <= settle_last;
        end
    end

    // accepted words; wraps silently, software reads differences
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_count <= 16'h0000;
        end else if (word_go) begin
            word_count <= word_count + 16'h0001;
        end
    end

    // discarded words: wrong length or held by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drop_count <= 16'h0000;
        end else if (word_drop) begin
            drop_count <= drop_count + 16'h0001;
        end
    end

    // wishbone request; ack blocks a second take, so one idle cycle is needed
    wire wb_live = wb_req.cyc && wb_req.stb;
    wire wb_hit = wb_live && !wb_ack_o;

    // address decode
    wire hit_input = (wb_req.adr == `SDLC_ADDR_INPUT);
    wire hit_conv = (wb_req.adr == `SDLC_ADDR_CONV);
    wire hit_status = (wb_req.adr == `SDLC_ADDR_STATUS);
    wire hit_ctrl = (wb_req.adr == `SDLC_ADDR_CTRL);
    wire hit_count = (wb_req.adr == `SDLC_ADDR_COUNT);
    wire wb_wr_ctrl = wb_hit && wb_req.we && hit_ctrl && wb_req.sel[0];

    // read words; unmapped addresses read zero
    wire [31:0] status_word = {29'h0, frame_open, settled, shutdown};
    wire [31:0] rd_input = {19'h0, input_reg};
    wire [31:0] rd_conv = {19'h0, code_value};
    wire [31:0] rd_ctrl = {31'h0, ctrl_hold};
    wire [31:0] rd_count = {drop_count, word_count};
    wire [31:0] rd_mux =
        hit_input ? rd_input :
        hit_conv ? rd_conv :
        hit_status ? status_word :
        hit_ctrl ? rd_ctrl :
        hit_count ? rd_count : 32'h0;

    // ack and read data stand for one cycle, data zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0;
        end
    end

    // control register: hold bit makes the link discard every word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_hold <= 1'b0;
        end else if (wb_wr_ctrl) begin
            ctrl_hold <= wb_req.dat[0];
        end
    end
endmodule

// File: dv/sdlc_top_asserts.sv
// port assertions for the load control block
`timescale 1ns/100ps
module sdlc_top_asserts #(parameter int SETTLE_CYCLES = 8) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire sdlc_pkg::sdlc_link_t link_in,
    input wire sdlc_pkg::sdlc_wb_req_t wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [12:0] code_value,
    input wire logic analog_enable,
    input wire logic settled
);
    import sdlc_pkg::*;
    // margin of two edges for where the settle count starts
    localparam int LEAD = SETTLE_CYCLES - 2;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // settle flag held low just after a wake
    sequence s_quiet;
        !settled [*4];
    endsequence
    a_ack_follows: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req.cyc && wb_req.stb))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
    a_code_at_select: assert property (
        !$stable(code_value) |-> $past(link_in.select_n)) else $error("code moved in frame");
    a_enable_at_select: assert property (
        !$stable(analog_enable) |-> $past(link_in.select_n)) else $error("enable moved in frame");
    a_code_wakes: assert property (
        !$stable(code_value) |-> ##[0:2] analog_enable) else $error("new code left asleep");
    a_wake_unsettled: assert property (
        $rose(analog_enable) |-> ##2 s_quiet) else $error("settled too soon after wake");
    a_settle_time: assert property (
        $rose(settled) |-> $past(rst_n, LEAD)) else $error("settled too soon after reset");
endmodule

// File: dv/sdlc_host_model.sv
// host serial master model driving the 3-wire link
`timescale 1ns/100ps
module sdlc_host_model (
    // time base
    input wire logic clk,
    // link pins
    output sdlc_pkg::sdlc_link_t link
);
    import sdlc_pkg::*;
    // select idle high, serial clock parked low outside frames
    initial link = '{1'b1, 1'b0, 1'b0};
    // n bits msb first at 320 ns a bit; split pauses after the first byte
    task automatic send(input logic [31:0] w, input int n, input bit split);
        int i;
        @(posedge clk);
        link.select_n <= 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            link.sdata <= w[i];
            repeat (4) @(posedge clk);
            link.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            link.sclk <= 1'b0;
            if (split && i == 8) repeat (16) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        link.select_n <= 1'b1;
        link.sdata <= ~link.sdata; // no stale bit left on the line
        repeat (12) @(posedge clk);
        #1;
    endtask
endmodule

// File: dv/testbench.sv
// self-checking bench for the load control block
`timescale 1ns/100ps
`include "sdlc_regs.svh"
module testbench;
    import sdlc_pkg::*;
    logic clk, rst_n, wb_ack_o, analog_enable, settled;
    sdlc_link_t link;
    sdlc_wb_req_t wb_req;
    logic [31:0] wb_dat_o, q;
    logic [12:0] code_value;
    int mismatches, tests_run, n;
    // 25 MHz clock
    always #20 clk = ~clk;
    sdlc_host_model u_sdlc_host_model (.clk(clk), .link(link));
    sdlc_top #(.SETTLE_CYCLES(40)) u_sdlc_top (.clk(clk), .rst_n(rst_n), .link_in(link),
        .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .code_value(code_value),
        .analog_enable(analog_enable), .settled(settled));
    task automatic summarize;
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic ck(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // one classic cycle; ack and data are taken at the edge that samples ack high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            summarize;
        end
        q = wb_dat_o;
        wb_req <= '0;
    endtask
    task automatic s_load;
        u_sdlc_host_model.send(32'h1FFF, 16, 1'b1);
        ck(32'h1FFF, code_value);
        u_sdlc_host_model.send(32'h2AAA, 16, 1'b0);
        ck(32'h1FFF, code_value);
        wb(1'b0, `SDLC_ADDR_INPUT, 32'h0);
        ck(32'h0AAA, q);
        u_sdlc_host_model.send(32'h7555, 16, 1'b0);
        ck(32'h1FFF, code_value);
        u_sdlc_host_model.send(32'h4000, 16, 1'b0);
        ck(32'h0AAA, code_value);
    endtask
    task automatic s_sleep;
        u_sdlc_host_model.send(32'hE123, 16, 1'b0);
        ck(32'h0, analog_enable);
        ck(32'h0AAA, code_value);
        wb(1'b0, `SDLC_ADDR_STATUS, 32'h0);
        ck(32'h1, q[0]);
        u_sdlc_host_model.send(32'h3234, 16, 1'b0);
        ck(32'h0, analog_enable);
        u_sdlc_host_model.send(32'h4000, 16, 1'b0);
        ck(32'h1234, code_value);
        ck(32'h0, settled);
        for (n = 0; n < 60 && settled !== 1'b1; n++) @(posedge clk);
        ck(32'h1, settled);
        u_sdlc_host_model.send(32'hE000, 16, 1'b0);
        u_sdlc_host_model.send(32'h9FFE, 16, 1'b0);
        ck(32'h1, analog_enable);
        ck(32'h1FFE, code_value);
    endtask
    task automatic s_drop;
        u_sdlc_host_model.send(32'h0005, 15, 1'b0);
        u_sdlc_host_model.send(32'h0003, 17, 1'b0);
        ck(32'h1FFE, code_value);
        wb(1'b0, `SDLC_ADDR_COUNT, 32'h0);
        ck(32'h2, q[31:16]);
        wb(1'b1, `SDLC_ADDR_CTRL, 32'h1);
        u_sdlc_host_model.send(32'h0007, 16, 1'b0);
        ck(32'h1FFE, code_value);
        wb(1'b1, `SDLC_ADDR_CTRL, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        ck(32'h0, q);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wb_req = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        ck(32'h0, code_value);
        ck(32'h0, settled);
        wb(1'b0, `SDLC_ADDR_INPUT, 32'h0);
        ck(32'h0, q);
        s_load;
        s_sleep;
        s_drop;
        summarize;
    end
endmodule
bind sdlc_top sdlc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sdlc_top_asserts (
    .clk(clk), .rst_n(rst_n), .link_in(link_in), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .code_value(code_value), .analog_enable(analog_enable),
    .settled(settled));
